// [core/demod_control_register_bank.sv]
// Summary of operation
// - Symbol rate word: 20 bits, reg 00 bit 7 down to reg 02 bit 4.
// - Symbol loop gain byte: proportional bits 2..0, integral bits 7..4.
// - Signed 20-bit carrier word, 04 bit 7 to 06 bit 4; sweep start.
// - Carrier gains: proportional bits 3..0, integral 7..4; 07 acquire, 08 steady.
// - Acquisition gains first; steady gains while demod lock is asserted, acquisition gains again when it drops.
// - Sweep step word: 16 bits, reg 09 MSB, reg 0A LSB.
// - Dwell symbols word: 16 bits, reg 0B MSB, reg 0C LSB.
// - Reg 0D gives the number of sweep steps.
// - Narrowband AGC start gain from upper six bits of reg 0E.
// - Control bit 0: zero two's complement, one offset binary input.
// - Control bit 1 zero inverts spectrum; bit 7 enables auto detection.
// - Control bit 2 enables DC bias cancellation.
// - Control bits 3/4 enable symbol/carrier tracking, else programmed frequency.
// - Control bit 5 holds the sweep; bit 6 lets narrowband AGC adapt.
// - Soft reset bits 0/1 low clear symbol/carrier frequency accumulators.
// - Bit 2 low clears wideband AGC in digital mode only; bit 3 low reloads narrowband AGC.
// - Bit 5 low stops sweep; bit 6 clears quality; bit 7 clears counters.
// - Wideband bit 0 selects external integrator; bit 1 inverts duty sense.
// - Digital mode: bit 2 zero freezes integrator; bits 7..5 time constant.
// - Wideband bit 3 forces tone to zero; bit 4 gates serial passthrough.
// - Serial mode: register pointer advances after each acknowledged data byte.
`timescale 1ns/1ps

module demod_control_register_bank
(
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    // Parallel host port
    input  wire logic                       chipSelectN,
    input  wire logic                       writeStrobeN,
    input  wire logic [4:0]                 host_reg_select,
    input  wire logic [7:0]                 host_byte_bus,
    // Serial host port
    input  wire logic                       serialModeSel,
    input  wire logic [6:0]                 serialDevAddr,
    input  wire logic                       serialClkIn,
    input  wire logic                       serialDataIn,
    output logic                            serialDataOut,
    output logic                            serialDataOe,
    // Serial passthrough pins, open drain
    output logic                            passthru_serial_clock,
    output logic                            passthru_serial_clock_oe,
    output logic                            passthru_serial_line,
    output logic                            passthru_serial_line_oe,
    // Demodulator side
    input  wire logic                       demod_lock_flag,
    output demod_ctrl_pkg::demod_cfg_t      demodCfg
);

    logic [7:0]                 regs_ff [demod_ctrl_pkg::NUM_REGS];
    logic [1:0]                 ceSync_ff;
    logic [1:0]                 weSync_ff;
    logic                       weDly_ff;
    logic [4:0]                 addrSync1_ff;
    logic [4:0]                 addrSync2_ff;
    logic [7:0]                 dataSync1_ff;
    logic [7:0]                 dataSync2_ff;
    logic [1:0]                 modeSync_ff;
    logic [1:0]                 sclSync_ff;
    logic [1:0]                 sdaSync_ff;
    logic [1:0]                 lockSync_ff;
    logic                       sclDly_ff;
    logic                       sdaDly_ff;
    demod_ctrl_pkg::i2c_state_t i2cState_ff;
    demod_ctrl_pkg::i2c_state_t ackNext_ff;
    logic [3:0]                 bitCnt_ff;
    logic [7:0]                 shift_ff;
    logic [4:0]                 regPtr_ff;
    logic                       ackHold_ff;
    logic                       dataAck_ff;
    logic                       parWrite;
    logic                       serWrite;
    logic                       sclRise;
    logic                       sclFall;
    logic                       startCond;
    logic                       stopCond;
    logic [7:0]                 nxt_shift;
    logic                       wrEn;
    logic [4:0]                 wrAddr;
    logic [7:0]                 wrData;

    function automatic logic isMapped(input logic [4:0] a);
        isMapped = a < 5'(demod_ctrl_pkg::NUM_REGS);
    endfunction

    function automatic logic [7:0] resetValue(input logic [4:0] a);
        case (a)
            demod_ctrl_pkg::OFS_CONTROL:  resetValue = demod_ctrl_pkg::RST_CONTROL;
            demod_ctrl_pkg::OFS_SOFT_RST: resetValue = demod_ctrl_pkg::RST_SOFT_RST;
            demod_ctrl_pkg::OFS_WB_AGC:   resetValue = demod_ctrl_pkg::RST_WB_AGC;
            default:                      resetValue = demod_ctrl_pkg::RST_DEFAULT;
        endcase
    endfunction

    // Pin synchronisers
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ceSync_ff    <= 2'h3;
            weSync_ff    <= 2'h3;
            weDly_ff     <= 1'b1;
            addrSync1_ff <= 5'h00;
            addrSync2_ff <= 5'h00;
            dataSync1_ff <= 8'h00;
            dataSync2_ff <= 8'h00;
            modeSync_ff  <= 2'h0;
            sclSync_ff   <= 2'h3;
            sdaSync_ff   <= 2'h3;
            lockSync_ff  <= 2'h0;
            sclDly_ff    <= 1'b1;
            sdaDly_ff    <= 1'b1;
        end
        else
        begin
            ceSync_ff    <= {ceSync_ff[0], chipSelectN};
            weSync_ff    <= {weSync_ff[0], writeStrobeN | chipSelectN};
            weDly_ff     <= weSync_ff[1];
            addrSync1_ff <= host_reg_select;
            addrSync2_ff <= addrSync1_ff;
            dataSync1_ff <= host_byte_bus;
            dataSync2_ff <= dataSync1_ff;
            modeSync_ff  <= {modeSync_ff[0], serialModeSel};
            sclSync_ff   <= {sclSync_ff[0], serialClkIn};
            sdaSync_ff   <= {sdaSync_ff[0], serialDataIn};
            lockSync_ff  <= {lockSync_ff[0], demod_lock_flag};
            sclDly_ff    <= sclSync_ff[1];
            sdaDly_ff    <= sdaSync_ff[1];
        end
    end

    // Parallel write on the leading edge of the combined strobe
    assign parWrite  = !modeSync_ff[1] && !ceSync_ff[1] && !weSync_ff[1] && weDly_ff;
    assign sclRise   = sclSync_ff[1] && !sclDly_ff;
    assign sclFall   = !sclSync_ff[1] && sclDly_ff;
    assign startCond = modeSync_ff[1] && sclSync_ff[1] && sclDly_ff && !sdaSync_ff[1] && sdaDly_ff;
    assign stopCond  = modeSync_ff[1] && sclSync_ff[1] && sclDly_ff && sdaSync_ff[1] && !sdaDly_ff;
    assign nxt_shift = {shift_ff[6:0], sdaSync_ff[1]};
    assign serWrite  = sclFall && ackHold_ff && i2cState_ff == demod_ctrl_pkg::I2C_ACK
                       && dataAck_ff && bitCnt_ff == 4'h0;
    assign wrEn      = parWrite || serWrite;
    assign wrAddr    = parWrite ? addrSync2_ff : regPtr_ff;
    assign wrData    = parWrite ? dataSync2_ff : shift_ff;

    // Serial slave: address, subaddress, then data bytes
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            i2cState_ff <= demod_ctrl_pkg::I2C_IDLE;
            ackNext_ff  <= demod_ctrl_pkg::I2C_IDLE;
            bitCnt_ff   <= 4'h0;
            shift_ff    <= 8'h00;
            regPtr_ff   <= 5'h00;
            ackHold_ff  <= 1'b0;
            dataAck_ff  <= 1'b0;
        end
        else if (!modeSync_ff[1] || stopCond)
        begin
            i2cState_ff <= demod_ctrl_pkg::I2C_IDLE;
            ackHold_ff  <= 1'b0;
        end
        else if (startCond)
        begin
            i2cState_ff <= demod_ctrl_pkg::I2C_DEVADDR;
            bitCnt_ff   <= 4'h0;
            ackHold_ff  <= 1'b0;
        end
        else
        begin
            case (i2cState_ff)
                demod_ctrl_pkg::I2C_DEVADDR, demod_ctrl_pkg::I2C_SUBADDR,
                demod_ctrl_pkg::I2C_DATA:
                begin
                    if (sclRise)
                    begin
                        shift_ff  <= nxt_shift;
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end
                    else if (sclFall && bitCnt_ff == 4'(demod_ctrl_pkg::I2C_BITS))
                    begin
                        bitCnt_ff   <= 4'h0;
                        i2cState_ff <= demod_ctrl_pkg::I2C_ACK;
                        dataAck_ff  <= i2cState_ff == demod_ctrl_pkg::I2C_DATA;
                        if (i2cState_ff == demod_ctrl_pkg::I2C_DEVADDR)
                        begin
                            ackHold_ff <= shift_ff == {serialDevAddr, 1'b0};
                            ackNext_ff <= demod_ctrl_pkg::I2C_SUBADDR;
                        end
                        else if (i2cState_ff == demod_ctrl_pkg::I2C_SUBADDR)
                        begin
                            ackHold_ff <= 1'b1;
                            regPtr_ff  <= shift_ff[4:0];
                            ackNext_ff <= demod_ctrl_pkg::I2C_DATA;
                        end
                        else
                        begin
                            ackHold_ff <= 1'b1;
                            ackNext_ff <= demod_ctrl_pkg::I2C_DATA;
                        end
                    end
                end
                demod_ctrl_pkg::I2C_ACK:
                begin
                    if (!ackHold_ff)
                    begin
                        i2cState_ff <= demod_ctrl_pkg::I2C_IGNORE;
                    end
                    else if (sclFall)
                    begin
                        ackHold_ff  <= 1'b0;
                        i2cState_ff <= ackNext_ff;
                        if (serWrite)
                        begin
                            regPtr_ff <= regPtr_ff + 5'h01;
                        end
                    end
                end
                default: i2cState_ff <= i2cState_ff;
            endcase
        end
    end

    // Register file, written from either port
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < demod_ctrl_pkg::NUM_REGS; i++)
            begin
                regs_ff[i] <= resetValue(5'(i));
            end
        end
        else if (wrEn && isMapped(wrAddr))
        begin
            regs_ff[wrAddr] <= wrData;
        end
    end

    // Serial acknowledge drive
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b0;
        end
        else
        begin
            serialDataOut <= 1'b0;
            serialDataOe  <= i2cState_ff == demod_ctrl_pkg::I2C_ACK && ackHold_ff && !sclFall;
        end
    end

    // Passthrough of the serial host lines
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            passthru_serial_clock    <= 1'b0;
            passthru_serial_clock_oe <= 1'b0;
            passthru_serial_line     <= 1'b0;
            passthru_serial_line_oe  <= 1'b0;
        end
        else
        begin
            passthru_serial_clock    <= 1'b0;
            passthru_serial_line     <= 1'b0;
            passthru_serial_clock_oe <= regs_ff[demod_ctrl_pkg::OFS_WB_AGC][demod_ctrl_pkg::WB_BYPASS]
                                        && !sclSync_ff[1];
            passthru_serial_line_oe  <= regs_ff[demod_ctrl_pkg::OFS_WB_AGC][demod_ctrl_pkg::WB_BYPASS]
                                        && !sdaSync_ff[1];
        end
    end

    // Demodulator configuration fields
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            demodCfg <= '0;
        end
        else
        begin
            demodCfg.symRateWord         <= {regs_ff[0], regs_ff[1], regs_ff[2][7:4]};
            demodCfg.symProportionalGain <= regs_ff[3][2:0];
            demodCfg.symIntegralGain     <= regs_ff[3][7:4];
            demodCfg.carrierFreqWord     <= {regs_ff[4], regs_ff[5], regs_ff[6][7:4]};
            demodCfg.carProportionalGain <= lockSync_ff[1] ? regs_ff[8][3:0]
                                                           : regs_ff[7][3:0];
            demodCfg.carIntegralGain     <= lockSync_ff[1] ? regs_ff[8][7:4]
                                                           : regs_ff[7][7:4];
            demodCfg.sweepStep           <= {regs_ff[9], regs_ff[10]};
            demodCfg.dwellSymbols        <= {regs_ff[11], regs_ff[12]};
            demodCfg.sweepStepCount      <= regs_ff[13];
            demodCfg.nbAgcStartGain      <= regs_ff[14][7:2];
            demodCfg.inputOffsetBinary   <= regs_ff[15][demod_ctrl_pkg::CTL_OFFSET_BIN];
            demodCfg.spectrumInvert      <= !regs_ff[15][demod_ctrl_pkg::CTL_SPEC_NORM];
            demodCfg.autoInvDetect       <= regs_ff[15][demod_ctrl_pkg::CTL_AUTO_INV];
            demodCfg.biasCancelEn        <= regs_ff[15][demod_ctrl_pkg::CTL_BIAS_CANC];
            demodCfg.symTrackEn          <= regs_ff[15][demod_ctrl_pkg::CTL_SYM_TRACK];
            demodCfg.carTrackEn          <= regs_ff[15][demod_ctrl_pkg::CTL_CAR_TRACK];
            demodCfg.sweepHold           <= regs_ff[15][demod_ctrl_pkg::CTL_SWEEP_HOLD];
            demodCfg.nbAgcAdapt          <= regs_ff[15][demod_ctrl_pkg::CTL_NB_ADAPT];
            demodCfg.clrSymAccum         <= !regs_ff[16][demod_ctrl_pkg::SR_SYM_ACC];
            demodCfg.clrCarAccum         <= !regs_ff[16][demod_ctrl_pkg::SR_CAR_ACC];
            demodCfg.clrWbAgcAccum       <= !regs_ff[16][demod_ctrl_pkg::SR_WB_ACC]
                                            && !regs_ff[17][demod_ctrl_pkg::WB_EXT_MODE];
            demodCfg.loadNbAgcAccum      <= !regs_ff[16][demod_ctrl_pkg::SR_NB_ACC];
            demodCfg.sweepDisable        <= !regs_ff[16][demod_ctrl_pkg::SR_SWEEP];
            demodCfg.clrQualityAccum     <= !regs_ff[16][demod_ctrl_pkg::SR_QUALITY];
            demodCfg.clrErrCounters      <= !regs_ff[16][demod_ctrl_pkg::SR_ERR_CNT];
            demodCfg.wbAgcExternal       <= regs_ff[17][demod_ctrl_pkg::WB_EXT_MODE];
            demodCfg.wbAgcInvert         <= regs_ff[17][demod_ctrl_pkg::WB_INVERT];
            demodCfg.wbAgcFreeze         <= !regs_ff[17][demod_ctrl_pkg::WB_RUN]
                                            && !regs_ff[17][demod_ctrl_pkg::WB_EXT_MODE];
            demodCfg.wbAgcTimeConst      <= regs_ff[17][demod_ctrl_pkg::WB_TC_LSB +: 3];
            demodCfg.lnbToneForceZero    <= regs_ff[17][demod_ctrl_pkg::WB_LNB_HOLD];
        end
    end

    // Checks
    par_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        parWrite && isMapped(addrSync2_ff) |=> regs_ff[$past(addrSync2_ff)] == $past(dataSync2_ff))
        else $error("parallel write not stored");
    ptr_advance_a: assert property (@(posedge clk_sys) disable iff (reset)
        serWrite |=> regPtr_ff == $past(regPtr_ff) + 5'h01)
        else $error("register pointer did not advance");
    sym_word_a: assert property (@(posedge clk_sys) disable iff (reset)
        ##2 demodCfg.symRateWord == $past({regs_ff[0], regs_ff[1], regs_ff[2][7:4]}))
        else $error("symbol rate word misassembled");
    gain_acquire_a: assert property (@(posedge clk_sys) disable iff (reset)
        !lockSync_ff[1] ##1 $stable(regs_ff[7]) |-> demodCfg.carIntegralGain == regs_ff[7][7:4])
        else $error("acquisition gains not used before lock");
    gain_steady_a: assert property (@(posedge clk_sys) disable iff (reset)
        lockSync_ff[1] ##1 $stable(regs_ff[8]) |-> demodCfg.carProportionalGain == regs_ff[8][3:0])
        else $error("steady gains not used after lock");
    wb_freeze_a: assert property (@(posedge clk_sys) disable iff (reset)
        regs_ff[17][0] |=> !demodCfg.wbAgcFreeze && !demodCfg.clrWbAgcAccum)
        else $error("external mode must not freeze or clear integrator");
    bypass_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        !regs_ff[17][4] |=> !passthru_serial_clock_oe && !passthru_serial_line_oe)
        else $error("passthrough driven while disabled");
    unmapped_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        wrEn && !isMapped(wrAddr) |=> $stable(regs_ff[17]) && $stable(regs_ff[0]))
        else $error("unmapped write changed a register");
    soft_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 demodCfg.clrCarAccum == !$past(regs_ff[16][1]))
        else $error("carrier accumulator clear does not follow bit");
    ack_drive_a: assert property (@(posedge clk_sys) disable iff (reset)
        serialDataOe |-> !serialDataOut && modeSync_ff[1])
        else $error("acknowledge drive outside serial mode");

    par_write_c: cover property (@(posedge clk_sys) disable iff (reset) parWrite);
    ser_burst_c: cover property (@(posedge clk_sys) disable iff (reset) serWrite ##[1:400] serWrite);
    lock_switch_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(lockSync_ff[1]));
    nack_c: cover property (@(posedge clk_sys) disable iff (reset)
        i2cState_ff == demod_ctrl_pkg::I2C_IGNORE);

endmodule

// [core/demod_ctrl_pkg.sv]
package demod_ctrl_pkg;

    localparam int         NUM_REGS      = 18;
    localparam logic [4:0] OFS_SYM_HI    = 5'h00;
    localparam logic [4:0] OFS_SYM_MID   = 5'h01;
    localparam logic [4:0] OFS_SYM_LO    = 5'h02;
    localparam logic [4:0] OFS_SYM_GAIN  = 5'h03;
    localparam logic [4:0] OFS_CAR_HI    = 5'h04;
    localparam logic [4:0] OFS_CAR_MID   = 5'h05;
    localparam logic [4:0] OFS_CAR_LO    = 5'h06;
    localparam logic [4:0] OFS_CAR_ACQ   = 5'h07;
    localparam logic [4:0] OFS_CAR_STEADY = 5'h08;
    localparam logic [4:0] OFS_STEP_HI   = 5'h09;
    localparam logic [4:0] OFS_STEP_LO   = 5'h0a;
    localparam logic [4:0] OFS_DWELL_HI  = 5'h0b;
    localparam logic [4:0] OFS_DWELL_LO  = 5'h0c;
    localparam logic [4:0] OFS_STEP_CNT  = 5'h0d;
    localparam logic [4:0] OFS_NB_AGC    = 5'h0e;
    localparam logic [4:0] OFS_CONTROL   = 5'h0f;
    localparam logic [4:0] OFS_SOFT_RST  = 5'h10;
    localparam logic [4:0] OFS_WB_AGC    = 5'h11;

    localparam logic [7:0] RST_DEFAULT   = 8'h00;
    localparam logic [7:0] RST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_SOFT_RST  = 8'hff;
    localparam logic [7:0] RST_WB_AGC    = 8'h14;

    // Control register bits
    localparam int CTL_OFFSET_BIN = 0;
    localparam int CTL_SPEC_NORM  = 1;
    localparam int CTL_BIAS_CANC  = 2;
    localparam int CTL_SYM_TRACK  = 3;
    localparam int CTL_CAR_TRACK  = 4;
    localparam int CTL_SWEEP_HOLD = 5;
    localparam int CTL_NB_ADAPT   = 6;
    localparam int CTL_AUTO_INV   = 7;
    // Soft reset bits, active low
    localparam int SR_SYM_ACC  = 0;
    localparam int SR_CAR_ACC  = 1;
    localparam int SR_WB_ACC   = 2;
    localparam int SR_NB_ACC   = 3;
    localparam int SR_SWEEP    = 5;
    localparam int SR_QUALITY  = 6;
    localparam int SR_ERR_CNT  = 7;
    // Wideband AGC bits
    localparam int WB_EXT_MODE = 0;
    localparam int WB_INVERT   = 1;
    localparam int WB_RUN      = 2;
    localparam int WB_LNB_HOLD = 3;
    localparam int WB_BYPASS   = 4;
    localparam int WB_TC_LSB   = 5;

    localparam int I2C_BITS = 8;

    typedef enum logic [2:0] {
        I2C_IDLE, I2C_DEVADDR, I2C_SUBADDR, I2C_DATA, I2C_ACK, I2C_IGNORE
    } i2c_state_t;

    typedef struct packed {
        logic [19:0]        symRateWord;
        logic [2:0]         symProportionalGain;
        logic [3:0]         symIntegralGain;
        logic signed [19:0] carrierFreqWord;
        logic [3:0]         carProportionalGain;
        logic [3:0]         carIntegralGain;
        logic [15:0]        sweepStep;
        logic [15:0]        dwellSymbols;
        logic [7:0]         sweepStepCount;
        logic [5:0]         nbAgcStartGain;
        logic               inputOffsetBinary;
        logic               spectrumInvert;
        logic               biasCancelEn;
        logic               symTrackEn;
        logic               carTrackEn;
        logic               sweepHold;
        logic               nbAgcAdapt;
        logic               autoInvDetect;
        logic               clrSymAccum;
        logic               clrCarAccum;
        logic               clrWbAgcAccum;
        logic               loadNbAgcAccum;
        logic               sweepDisable;
        logic               clrQualityAccum;
        logic               clrErrCounters;
        logic               wbAgcExternal;
        logic               wbAgcInvert;
        logic               wbAgcFreeze;
        logic               lnbToneForceZero;
        logic [2:0]         wbAgcTimeConst;
    } demod_cfg_t;

endpackage

// [tb/demod_control_register_bank_tb_top.sv]
`timescale 1ns/1ps
module demod_control_register_bank_tb_top;
    logic                       clk_sys, reset, chipSelectN, writeStrobeN, serialModeSel;
    logic                       serialClkIn, sdaM, demod_lock_flag, ackSeen;
    logic [4:0]                 host_reg_select;
    logic [7:0]                 host_byte_bus, d1, d2;
    logic [6:0]                 serialDevAddr;
    logic                       serialDataOut, serialDataOe, clkOe, lineOe, ptClk, ptLine;
    logic [7:0]                 m [18];
    int                         num_errors, checked, cyc, seed;
    demod_ctrl_pkg::demod_cfg_t demodCfg;
    wire                        sda = sdaM & !serialDataOe;
    demod_control_register_bank uut (.clk_sys(clk_sys), .reset(reset),
        .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN),
        .host_reg_select(host_reg_select), .host_byte_bus(host_byte_bus),
        .serialModeSel(serialModeSel), .serialDevAddr(serialDevAddr),
        .serialClkIn(serialClkIn), .serialDataIn(sda), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .passthru_serial_clock(ptClk),
        .passthru_serial_clock_oe(clkOe), .passthru_serial_line(ptLine),
        .passthru_serial_line_oe(lineOe), .demod_lock_flag(demod_lock_flag),
        .demodCfg(demodCfg));
    function automatic demod_ctrl_pkg::demod_cfg_t expc(input logic lk);
        demod_ctrl_pkg::demod_cfg_t c;
        logic [7:0] g;
        g = lk ? m[8] : m[7];
        c = {m[0], m[1], m[2][7:4], m[3][2:0], m[3][7:4], m[4], m[5], m[6][7:4],
             g[3:0], g[7:4], m[9], m[10], m[11], m[12], m[13], m[14][7:2], m[15][0],
             !m[15][1], m[15][2], m[15][3], m[15][4], m[15][5], m[15][6], m[15][7],
             ~m[16][0], ~m[16][1], !m[16][2] & !m[17][0], ~m[16][3],
             ~m[16][5], ~m[16][6], ~m[16][7], m[17][0], m[17][1],
             !m[17][2] & !m[17][0], m[17][3], m[17][7:5]};
        return c;
    endfunction
    task automatic cmp(input string n, input logic [127:0] x, y);
        checked++;
        if (y !== x)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, y);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk;
        tick(6);
        cmp("demodCfg", expc(demod_lock_flag), demodCfg);
        cmp("clkOe", m[17][4] & !serialClkIn, clkOe);
        cmp("lineOe", m[17][4] & !sda, lineOe);
        cmp("ptClk", 1'b0, ptClk);
        cmp("ptLine", 1'b0, ptLine);
        cmp("serialDataOut", 1'b0, serialDataOut);
    endtask
    task automatic pw(input logic [4:0] a, input logic [7:0] d);
        tick(1);
        host_reg_select = a;
        host_byte_bus = d;
        tick(4);
        {chipSelectN, writeStrobeN} = 2'b00;
        tick(5);
        {chipSelectN, writeStrobeN} = 2'b11;
        if (a < 18) m[a] = d;
        chk();
    endtask
    task automatic sb(input logic b);
        sdaM = b;
        tick(4);
        serialClkIn = 1;
        tick(3);
        ackSeen = serialDataOe;
        tick(1);
        serialClkIn = 0;
        tick(4);
    endtask
    task automatic sbyte(input logic [7:0] b, input logic ak);
        for (int i = 7; i >= 0; i--) sb(b[i]);
        sb(1'b1);
        cmp("ack", ak, ackSeen);
    endtask
    task automatic edges(input logic s);
        serialModeSel = 1;
        sdaM = !s;
        tick(4);
        serialClkIn = 1;
        tick(4);
        sdaM = s;
        tick(4);
        serialClkIn = s;
        tick(4);
    endtask
    task end_sim;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        seed = 32'h5aaad2f3;
        {reset, chipSelectN, writeStrobeN, sdaM} = 4'hf;
        {serialModeSel, serialClkIn, demod_lock_flag, host_reg_select, host_byte_bus} = '0;
        serialDevAddr = 7'($random(seed));
        m = '{default: demod_ctrl_pkg::RST_DEFAULT};
        m[16] = demod_ctrl_pkg::RST_SOFT_RST;
        m[17] = demod_ctrl_pkg::RST_WB_AGC;
        tick(16);
        reset = 0;
        chk();
        for (int a = 0; a < 20; a++) pw(5'(a), 8'($random(seed)));
        repeat (40) pw(5'($random(seed)), 8'($random(seed)));
        for (int k = 0; k < 6; k++) pw(5'h10 + 5'(k[0]), {4'($random(seed)), 2'(k), 2'(k)});
        pw(5'h03, 8'hb6);
        pw(5'h07, 8'h77);
        pw(5'h08, 8'h45);
        pw(5'h10, 8'hef);
        demod_lock_flag = 1;
        chk();
        pw(5'h08, 8'($random(seed)));
        demod_lock_flag = 0;
        chk();
        {d1, d2} = 16'($random(seed));
        edges(1'b0);
        sbyte({serialDevAddr, 1'b0}, 1'b1);
        sbyte(8'h0d, 1'b1);
        sbyte(d1, 1'b1);
        sbyte(d2, 1'b1);
        edges(1'b1);
        {m[13], m[14]} = {d1, d2};
        chk();
        for (int k = 0; k < 2; k++)
        begin
            edges(1'b0);
            sbyte({serialDevAddr ^ 7'(1 - k), 1'(k)}, 1'b0);
            sbyte(8'h0d, 1'b0);
            edges(1'b1);
            chk();
        end
        end_sim();
    end
endmodule
